// *** fppt_chk_props.sv ***
/* Checker for fppt_flash_ctrl: APB, program and protect relations.
   Bound to the controller; sees its ports only. */
`default_nettype none
module fppt_chk
(
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_prog_req,
    input wire logic        cpu_prog_ack,
    input wire logic        dbg_prog_ack,
    input wire logic        prog_ok,
    input wire logic        cpu_hold
);
    timeunit 1ns;
    timeprecision 100ps;
    import fppt_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic        acc;
    logic [11:0] idx;
    logic        sel_prot;
    logic [7:0]  prot_img;
    assign acc = psel && penable && pready && !pslverr;
    assign idx = paddr[13:2];
    // Shadow of protect select and protect bits
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_prot <= 1'b0;
            prot_img <= 8'h00;
        end
        else if (acc && pwrite && idx == IDX_FLASH_CMD)
            sel_prot <= (pwdata[7:0] == CMD_PROT_SEL);
        else if (acc && pwrite && idx == IDX_PAGE_PROT && sel_prot)
            prot_img <= prot_img | pwdata[7:0];
    end
    chk_cpu_ack_pulse: assert property (cpu_prog_ack |=> !cpu_prog_ack)
        else $error("cpu ack longer than one cycle");
    chk_dbg_ack_pulse: assert property (dbg_prog_ack |=> !dbg_prog_ack)
        else $error("dbg ack longer than one cycle");
    chk_ack_has_req: assert property (cpu_prog_ack |-> $past(cpu_prog_req))
        else $error("cpu ack without request");
    chk_ok_held_cpu: assert property ((cpu_prog_ack || dbg_prog_ack) && prog_ok
        |-> $past(cpu_hold, 2)) else $error("program done without cpu hold");
    chk_refused_no_hold: assert property ((cpu_prog_ack || dbg_prog_ack) && !prog_ok
        |-> !$past(cpu_hold)) else $error("refused program held cpu");
    chk_cmd_relocks: assert property (acc && pwrite && idx == IDX_FLASH_CMD
        && pwdata[7:0] != CMD_MASS && pwdata[7:0] != CMD_PAGE
        |=> (!(cpu_prog_ack || dbg_prog_ack) || !prog_ok) [*8])
        else $error("program accepted after relock");
    chk_protect_image: assert property (acc && !pwrite && idx == IDX_PAGE_PROT
        && sel_prot |-> prdata[7:0] == prot_img) else $error("protect bits wrong");
    chk_zero_wait: assert property (psel && !penable |=> pready)
        else $error("apb access not answered");
    cover property (cpu_prog_ack && prog_ok);
    cover property (cpu_prog_ack && !prog_ok);
    cover property ($rose(cpu_hold));
endmodule : fppt_chk
bind fppt_flash_ctrl fppt_chk u_chk (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_prog_req(cpu_prog_req),
    .cpu_prog_ack(cpu_prog_ack), .dbg_prog_ack(dbg_prog_ack), .prog_ok(prog_ok),
    .cpu_hold(cpu_hold));
`default_nettype wire

// *** fppt_flash_ctrl.sv ***
/*
 * Flash controller slice: sector protection, unlock and erase enable,
 * byte programming from two requesters, main and information arrays,
 * trim index and trim data access over APB.
 * Assumes an APB master on mclk and requesters that hold req until ack.
 */
`default_nettype none

// What this block does
// - Sector protect clears to zero on reset
// - Protected sector refuses program and erase
// - Protect bits are set-only until reset
// - Programming needs unlock plus enabled erase command
// - Mass erase enable opens every location
// - Page erase enable opens selected page only
// - Erased bytes read back as FFH
// - Programming only clears bits to zero
// - Serve debugger and processor program requests
// - Hold processor idle while flash is busy
// - Other command values end programming, relock
// - Non-5EH command restores page select access
// - Trim index register, resets to zero
// - Trim index bits 4:0 map to information index plus 20h
// - Trim data reads and writes addressed byte
module fppt_flash_ctrl
(
    input  wire logic                           mclk,
    input  wire logic                           resetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [fppt_pkg::APB_AW-1:0]    paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           cpu_prog_req,
    input  wire logic [fppt_pkg::FLASH_AW-1:0]  cpu_prog_addr,
    input  wire logic [7:0]                     cpu_prog_data,
    output logic                                cpu_prog_ack,
    input  wire logic                           dbg_prog_req,
    input  wire logic [fppt_pkg::FLASH_AW-1:0]  dbg_prog_addr,
    input  wire logic [7:0]                     dbg_prog_data,
    output logic                                dbg_prog_ack,
    output logic                                prog_ok,
    output logic                                cpu_hold,
    input  wire logic [fppt_pkg::FLASH_AW-1:0]  rd_addr,
    output logic      [7:0]                     rd_data
);
    import fppt_pkg::*;

    logic [7:0]          flash_mem [0:FLASH_DEPTH-1];
    logic [7:0]          info_mem  [0:INFO_DEPTH-1];

    fppt_lock_t          lock_st;
    fppt_eng_t           eng_st;
    logic [7:0]          trim_index;
    logic [7:0]          sector_protect;
    logic [7:0]          page_sel;
    logic                prot_sel;

    logic [FLASH_AW-1:0] ptr;
    logic [FLASH_AW-1:0] end_ptr;
    logic [2:0]          cnt;
    logic [FLASH_AW-1:0] prog_addr;
    logic [7:0]          prog_data;
    logic                prog_from_dbg;
    logic                prog_pass;

    logic [11:0]         idx;
    logic                aligned;
    logic                mapped;
    logic                busy;
    logic                setup;
    logic                wr_ok;
    logic                cmd_wr;
    logic [7:0]          wbyte;
    logic [INFO_AW-1:0]  trim_addr;
    logic [7:0]          status;
    logic [31:0]         rd_mux;
    logic                unlocked;
    logic                mass_go;
    logic                page_go;
    logic                cmd_pending;
    logic                req_any;
    logic                pick_dbg;
    logic [FLASH_AW-1:0] req_addr;
    logic [7:0]          req_data;
    logic                req_allowed;
    logic                prog_start;
    logic                mem_we;
    logic [FLASH_AW-1:0] mem_wa;
    logic [7:0]          mem_wd;

    // Bus decode
    assign idx      = paddr[APB_AW-1:2];
    assign aligned  = (paddr[1:0] == 2'h0);
    assign mapped   = (idx == IDX_TRIM_INDEX) || (idx == IDX_TRIM_DATA)
                   || (idx == IDX_FLASH_CMD)  || (idx == IDX_PAGE_PROT);
    assign busy     = (eng_st != eng_idle);
    assign setup    = psel && !penable;
    assign wr_ok    = psel && penable && pready && pwrite && !pslverr;
    assign cmd_wr   = wr_ok && (idx == IDX_FLASH_CMD);
    assign wbyte    = pwdata[7:0];
    assign trim_addr = TRIM_BASE + {1'b0, trim_index[4:0]};
    assign unlocked = (lock_st == lk_open) || (lock_st == lk_mass_en)
                   || (lock_st == lk_page_en);
    assign status   = {3'h0, busy, prot_sel, lock_st == lk_page_en,
                       lock_st == lk_mass_en, unlocked};

    // Read data mux
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (idx)
            IDX_TRIM_INDEX: rd_mux[7:0] = trim_index;
            IDX_TRIM_DATA:  rd_mux[7:0] = info_mem[trim_addr];
            IDX_FLASH_CMD:  rd_mux[7:0] = status;
            IDX_PAGE_PROT:  rd_mux[7:0] = prot_sel ? sector_protect : page_sel;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // APB slave: one access cycle, answer captured in setup
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (setup)
        begin
            pready  <= 1'b1;
            pslverr <= !aligned || !mapped || (pwrite && (idx == IDX_FLASH_CMD) && busy);
            prdata  <= (aligned && mapped && !pwrite) ? rd_mux : 32'h0000_0000;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Erase enables, refused on protection
    assign mass_go = cmd_wr && (wbyte == CMD_MASS) && unlocked
                  && (sector_protect == 8'h00);
    assign page_go = cmd_wr && (wbyte == CMD_PAGE) && unlocked
                  && !sector_protect[page_sel[3:1]];

    // Unlock and erase enable state
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            lock_st <= lk_locked;
        end
        else if (cmd_wr)
        begin
            unique case (wbyte)
                CMD_KEY1: lock_st <= (lock_st == lk_locked) ? lk_key1 : lk_locked;
                CMD_KEY2: lock_st <= (lock_st == lk_key1) ? lk_open : lk_locked;
                CMD_MASS: lock_st <= mass_go ? lk_mass_en : lk_locked;
                CMD_PAGE: lock_st <= page_go ? lk_page_en : lk_locked;
                default:  lock_st <= lk_locked;
            endcase
        end
    end

    // Protect register select
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            prot_sel <= 1'b0;
        end
        else if (cmd_wr)
        begin
            prot_sel <= (wbyte == CMD_PROT_SEL);
        end
    end

    // Trim index
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            trim_index <= RST_TRIM_INDEX;
        end
        else if (wr_ok && (idx == IDX_TRIM_INDEX))
        begin
            trim_index <= wbyte;
        end
    end

    // Sector protect, set-only
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sector_protect <= RST_SECT_PROT;
        end
        else if (wr_ok && (idx == IDX_PAGE_PROT) && prot_sel)
        begin
            sector_protect <= sector_protect | wbyte;
        end
    end

    // Page select at the shared address
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            page_sel <= RST_PAGE_SEL;
        end
        else if (wr_ok && (idx == IDX_PAGE_PROT) && !prot_sel)
        begin
            page_sel <= wbyte;
        end
    end

    // Trim byte storage in the information area
    always_ff @(posedge mclk)
    begin
        if (wr_ok && (idx == IDX_TRIM_DATA))
        begin
            info_mem[trim_addr] <= wbyte;
        end
    end

    // Program request arbitration, debugger first
    assign cmd_pending = psel && pwrite && (idx == IDX_FLASH_CMD);
    assign req_any     = cpu_prog_req || dbg_prog_req;
    assign pick_dbg    = dbg_prog_req;
    assign req_addr    = pick_dbg ? dbg_prog_addr : cpu_prog_addr;
    assign req_data    = pick_dbg ? dbg_prog_data : cpu_prog_data;
    assign req_allowed = ((lock_st == lk_mass_en)
                       || ((lock_st == lk_page_en)
                           && (req_addr[FLASH_AW-1:PAGE_LSB] == page_sel[3:0])))
                      && !sector_protect[req_addr[FLASH_AW-1:SECT_LSB]];
    assign prog_start  = (eng_st == eng_idle) && req_any && !cmd_pending
                      && !cpu_prog_ack && !dbg_prog_ack;

    // Erase and program engine
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            eng_st        <= eng_idle;
            ptr           <= '0;
            end_ptr       <= '0;
            cnt           <= 3'h0;
            prog_addr     <= '0;
            prog_data     <= 8'h00;
            prog_from_dbg <= 1'b0;
            prog_pass     <= 1'b0;
            cpu_hold      <= 1'b0;
        end
        else
        begin
            unique case (eng_st)
                eng_idle:
                begin
                    if (mass_go)
                    begin
                        ptr      <= '0;
                        end_ptr  <= FLASH_LAST;
                        eng_st   <= eng_erase;
                        cpu_hold <= 1'b1;
                    end
                    else if (page_go)
                    begin
                        ptr      <= {page_sel[3:0], {PAGE_LSB{1'b0}}};
                        end_ptr  <= {page_sel[3:0], PAGE_OFFS_LAST};
                        eng_st   <= eng_erase;
                        cpu_hold <= 1'b1;
                    end
                    else if (prog_start)
                    begin
                        prog_addr     <= req_addr;
                        prog_data     <= req_data;
                        prog_from_dbg <= pick_dbg;
                        prog_pass     <= req_allowed;
                        cnt           <= 3'h0;
                        eng_st        <= req_allowed ? eng_prog : eng_done;
                        cpu_hold      <= req_allowed;
                    end
                end
                eng_erase:
                begin
                    ptr <= ptr + 13'h1;
                    if (ptr == end_ptr)
                    begin
                        eng_st   <= eng_idle;
                        cpu_hold <= 1'b0;
                    end
                end
                eng_prog:
                begin
                    cnt <= cnt + 3'h1;
                    if (cnt == PROG_LAST)
                    begin
                        eng_st   <= eng_done;
                        cpu_hold <= 1'b0;
                    end
                end
                eng_done:
                begin
                    eng_st <= eng_idle;
                end
            endcase
        end
    end

    // Completion handshake to the requester
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_prog_ack <= 1'b0;
            dbg_prog_ack <= 1'b0;
            prog_ok      <= 1'b0;
        end
        else
        begin
            cpu_prog_ack <= (eng_st == eng_done) && !prog_from_dbg;
            dbg_prog_ack <= (eng_st == eng_done) && prog_from_dbg;
            if (eng_st == eng_done)
            begin
                prog_ok <= prog_pass;
            end
        end
    end

    // Array write port
    assign mem_we = (eng_st == eng_erase) || ((eng_st == eng_prog) && (cnt == PROG_LAST));
    assign mem_wa = (eng_st == eng_erase) ? ptr : prog_addr;
    assign mem_wd = (eng_st == eng_erase) ? ERASED_BYTE
                                          : (flash_mem[prog_addr] & prog_data);

    always_ff @(posedge mclk)
    begin
        if (mem_we)
        begin
            flash_mem[mem_wa] <= mem_wd;
        end
    end

    // Array read port
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_data <= 8'h00;
        end
        else
        begin
            rd_data <= flash_mem[rd_addr];
        end
    end

endmodule : fppt_flash_ctrl

`default_nettype wire

// *** fppt_pkg.sv ***
/*
 * Package for the flash protect, byte program and trim access block.
 * Register word indices, command codes, reset values, array geometry and
 * program timing. Assumes a 20 MHz mclk and a 32-bit APB master.
 */
`default_nettype none

package fppt_pkg;

    // Clock and program timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_NS  = 200;
    localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] PROG_LAST = 3'(PROG_CYCLES - 1);

    // Array geometry: 8 KB main array, 1 KB sectors, 512 byte pages
    localparam int FLASH_AW    = 13;
    localparam int FLASH_DEPTH = 8192;
    localparam int SECT_LSB    = 10;
    localparam int PAGE_LSB    = 9;
    localparam int INFO_AW     = 6;
    localparam int INFO_DEPTH  = 64;
    localparam logic [INFO_AW-1:0]  TRIM_BASE   = 6'h20;
    localparam logic [FLASH_AW-1:0] FLASH_LAST  = 13'h1FFF;
    localparam logic [PAGE_LSB-1:0] PAGE_OFFS_LAST = 9'h1FF;
    localparam logic [7:0]          ERASED_BYTE = 8'hFF;

    // Register word indices; byte address is four times the index
    localparam logic [11:0] IDX_TRIM_INDEX = 12'hFF6;
    localparam logic [11:0] IDX_TRIM_DATA  = 12'hFF7;
    localparam logic [11:0] IDX_FLASH_CMD  = 12'hFF8;
    localparam logic [11:0] IDX_PAGE_PROT  = 12'hFF9;
    localparam int          APB_AW         = 14;

    // Flash command codes
    localparam logic [7:0] CMD_RESET    = 8'h00;
    localparam logic [7:0] CMD_PROT_SEL = 8'h5E;
    localparam logic [7:0] CMD_KEY1     = 8'h73;
    localparam logic [7:0] CMD_KEY2     = 8'h8C;
    localparam logic [7:0] CMD_MASS     = 8'h95;
    localparam logic [7:0] CMD_PAGE     = 8'h63;

    // Reset values
    localparam logic [7:0] RST_TRIM_INDEX = 8'h00;
    localparam logic [7:0] RST_SECT_PROT  = 8'h00;
    localparam logic [7:0] RST_PAGE_SEL   = 8'h00;

    typedef enum logic [2:0] {
        lk_locked, lk_key1, lk_open, lk_mass_en, lk_page_en
    } fppt_lock_t;

    typedef enum logic [1:0] {
        eng_idle, eng_erase, eng_prog, eng_done
    } fppt_eng_t;

endpackage : fppt_pkg

`default_nettype wire

// *** fppt_req_model.sv ***
/* Byte-program requester: processor or debugger side.
   Holds a request until ack, then releases it. */
`default_nettype none
module fppt_req_model
(
    input  wire logic                         mclk,
    output logic                              req,
    output logic [fppt_pkg::FLASH_AW-1:0]     addr,
    output logic [7:0]                        data,
    input  wire logic                         ack,
    input  wire logic                         ok
);
    timeunit 1ns;
    timeprecision 100ps;
    import fppt_pkg::*;
    initial
    begin
        req = 1'b0;
        addr = '0;
        data = 8'h00;
    end
    task automatic do_prog(input logic [FLASH_AW-1:0] a, input logic [7:0] d,
                           output logic res);
        @(posedge mclk);
        req <= 1'b1;
        addr <= a;
        data <= d;
        do
        begin
            @(posedge mclk);
        end
        while (ack !== 1'b1);
        res = ok;
        req <= 1'b0;
        addr <= ~a;
        data <= ~d;
    endtask : do_prog
endmodule : fppt_req_model
`default_nettype wire

// *** test_flash_protect_program_trim.sv ***
/* Bench for fppt_flash_ctrl: APB master, two requesters.
   Assumes the design answers APB with zero wait states. */
`default_nettype none
module test_flash_protect_program_trim;
    timeunit 1ns;
    timeprecision 100ps;
    import fppt_pkg::*;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic cq, ca, dq, da, prog_ok, cpu_hold, ok;
    logic [12:0] c_a, d_a, rd_addr;
    logic [7:0] c_d, d_d, rd_data;
    int n_mismatch = 0;
    int comparisons = 0;
    fppt_flash_ctrl DUT (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_prog_req(cq), .cpu_prog_addr(c_a),
        .cpu_prog_data(c_d), .cpu_prog_ack(ca), .dbg_prog_req(dq), .dbg_prog_addr(d_a),
        .dbg_prog_data(d_d), .dbg_prog_ack(da), .prog_ok(prog_ok), .cpu_hold(cpu_hold),
        .rd_addr(rd_addr), .rd_data(rd_data));
    fppt_req_model u_cpu (.mclk(mclk), .req(cq), .addr(c_a), .data(c_d), .ack(ca),
        .ok(prog_ok));
    fppt_req_model u_dbg (.mclk(mclk), .req(dq), .addr(d_a), .data(d_d), .ack(da),
        .ok(prog_ok));
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, wd, r, e);
    endtask : wr
    task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        chk(r, exp);
    endtask : rd
    task automatic arr(input logic [12:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rd_addr <= a;
        repeat (2) @(posedge mclk);
        chk({24'h0, rd_data}, {24'h0, exp});
    endtask : arr
    task automatic wait_idle;
        @(posedge mclk);
        chk({31'h0, cpu_hold}, 32'h1);
        while (cpu_hold !== 1'b0)
        begin
            @(posedge mclk);
        end
    endtask : wait_idle
    task automatic unlock;
        wr(IDX_FLASH_CMD, CMD_KEY1);
        wr(IDX_FLASH_CMD, CMD_KEY2);
    endtask : unlock
    task automatic do_reset;
        resetn <= 1'b0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
    endtask : do_reset
    task automatic t_reset_vals;
        logic [31:0] r;
        logic e;
        rd(IDX_TRIM_INDEX, 32'h0);
        wr(IDX_FLASH_CMD, CMD_RESET);
        wr(IDX_FLASH_CMD, CMD_PROT_SEL);
        rd(IDX_FLASH_CMD, 32'h08);
        rd(IDX_PAGE_PROT, 32'h0);
        apb(1'b0, 12'hFF5, 8'h00, r, e);
        chk({31'h0, e}, 32'h1);
        wr(IDX_FLASH_CMD, CMD_RESET);
        $display("reset values done");
    endtask : t_reset_vals
    task automatic t_mass;
        unlock();
        wr(IDX_FLASH_CMD, CMD_MASS);
        wait_idle();
        rd(IDX_FLASH_CMD, 32'h03);
        arr(13'h0000, ERASED_BYTE);
        arr(13'h1FFF, ERASED_BYTE);
        u_cpu.do_prog(13'h1FFF, 8'hF0, ok);
        chk({31'h0, ok}, 32'h1);
        arr(13'h1FFF, 8'hF0);
        u_cpu.do_prog(13'h1FFF, 8'h3C, ok);
        arr(13'h1FFF, 8'h30);
        u_dbg.do_prog(13'h0100, 8'h55, ok);
        chk({31'h0, ok}, 32'h1);
        arr(13'h0100, 8'h55);
        wr(IDX_FLASH_CMD, CMD_RESET);
        rd(IDX_FLASH_CMD, 32'h00);
        u_dbg.do_prog(13'h0100, 8'h00, ok);
        chk({31'h0, ok}, 32'h0);
        arr(13'h0100, 8'h55);
        $display("mass program done");
    endtask : t_mass
    task automatic t_page;
        logic [31:0] r;
        logic e;
        wr(IDX_PAGE_PROT, 8'h02);
        rd(IDX_PAGE_PROT, 32'h02);
        unlock();
        wr(IDX_FLASH_CMD, CMD_PAGE);
        apb(1'b1, IDX_FLASH_CMD, CMD_RESET, r, e);
        chk({31'h0, e}, 32'h1);
        wait_idle();
        rd(IDX_FLASH_CMD, 32'h05);
        u_cpu.do_prog(13'h05FF, 8'hA5, ok);
        chk({31'h0, ok}, 32'h1);
        arr(13'h05FF, 8'hA5);
        u_cpu.do_prog(13'h0600, 8'h00, ok);
        chk({31'h0, ok}, 32'h0);
        arr(13'h0600, ERASED_BYTE);
        arr(13'h1FFF, 8'h30);
        $display("page program done");
    endtask : t_page
    task automatic t_protect;
        wr(IDX_FLASH_CMD, CMD_PROT_SEL);
        wr(IDX_PAGE_PROT, 8'h06);
        wr(IDX_PAGE_PROT, 8'h00);
        rd(IDX_PAGE_PROT, 32'h06);
        wr(IDX_FLASH_CMD, CMD_RESET);
        rd(IDX_PAGE_PROT, 32'h02);
        unlock();
        wr(IDX_FLASH_CMD, CMD_PAGE);
        rd(IDX_FLASH_CMD, 32'h00);
        arr(13'h05FF, 8'hA5);
        unlock();
        wr(IDX_FLASH_CMD, CMD_MASS);
        rd(IDX_FLASH_CMD, 32'h00);
        arr(13'h1FFF, 8'h30);
        $display("protect done");
    endtask : t_protect
    task automatic t_trim;
        wr(IDX_TRIM_INDEX, 8'h1F);
        wr(IDX_TRIM_DATA, 8'hA5);
        wr(IDX_TRIM_INDEX, 8'h00);
        wr(IDX_TRIM_DATA, 8'h5A);
        rd(IDX_TRIM_DATA, 32'h5A);
        wr(IDX_TRIM_INDEX, 8'h1F);
        rd(IDX_TRIM_INDEX, 32'h1F);
        rd(IDX_TRIM_DATA, 32'hA5);
        $display("trim done");
    endtask : t_trim
    task automatic t_rereset;
        do_reset();
        wr(IDX_FLASH_CMD, CMD_PROT_SEL);
        rd(IDX_PAGE_PROT, 32'h0);
        rd(IDX_TRIM_INDEX, 32'h0);
        $display("second reset done");
    endtask : t_rereset
    initial
    begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        rd_addr = '0;
        do_reset();
        t_reset_vals();
        t_mass();
        t_page();
        t_protect();
        t_trim();
        t_rereset();
        give_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        give_verdict();
    end
endmodule : test_flash_protect_program_trim
`default_nettype wire
